//--- shared/mdp_params.svh
// timing counts, pin positions and reset values of the low-power dram command core
// How it works
// (R1) controller waits write-to-read turnaround before a read that must not truncate
// (R2) read interrupting a write stores only earlier pairs; later pairs masked
// (R3) controller waits write recovery before precharging the written bank
// (R4) precharge truncating a write stores earlier pairs only; then row precharge time
// (R5) precharge closes one or all rows; activation allowed after row precharge time
// (R6) address bit ten picks all banks, else bank select picks one bank
// (R7) controller activates a row before reading or writing an idle bank
// (R8) precharge to an idle or already precharging bank acts as no-operation
// (R9) read or write with bit ten high precharges its bank after the burst
// (R10) controller leaves a bank alone until auto precharge completes
// (R11) every row refreshed within each rolling 64 ms window
// (R12) each auto refresh advances the internal refresh row counter
// (R13) auto refresh with clock enable low enters self refresh
// (R14) self refresh runs on an internal timer; minimum stay is refresh cycle time
// (R15) controller restores clock, raises clock enable, waits exit delay
// (R16) clock enable low while idle enters precharge or active power-down
// (R17) power-down lasts a minimum time; exit is clock enable high with nop
// (R18) controller waits power-down exit time before a valid command
// (R19) burst terminate with clock enable low enters deepest sleep state
// (R20) deepest sleep state loses array and both mode register contents
// (R21) controller exits deepest sleep with 200 us of nops then reinitialises; the bench sends three nop or deselect cycles, then a mode register set
// (R22) controller stops clock only when idle, timing met, clock enable high
// (R23) controller sends one nop after restarting a stopped clock
// (R24) each bank keeps its own state and cycle counters set by parameters
`ifndef MDP_PARAMS_SVH
`define MDP_PARAMS_SVH
`define MDP_CLK_NS      4
`define MDP_BURST_PAIRS 2
`define MDP_T_RP        5
`define MDP_T_WR        4
`define MDP_T_WTR       2
`define MDP_T_RFC       18
`define MDP_T_CKE       2
`define MDP_REF_MS      64
`define MDP_ROWS        8192
`define MDP_REFI_CYC    ((`MDP_REF_MS * 1000000) / (`MDP_ROWS * `MDP_CLK_NS))
`define MDP_A10         10
`define MDP_ARRAY_RST   1'b1
`define MDP_MODE_RST    1'b1
`endif

//--- shared/mdp_pkg.sv
// types shared by the dram command core and its bank trackers
package mdp_pkg;
   typedef enum logic [1:0] {BK_IDLE, BK_ACTIVE, BK_PRECHG} mdp_bank_e;
   typedef enum logic [2:0] {PW_NORMAL, PW_SELF_REF, PW_PRE_PD, PW_ACT_PD,
                             PW_DEEPEST} mdp_pwr_e;
   typedef enum logic [2:0] {CMD_DESEL, CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_BST,
                             CMD_PRE, CMD_AREF} mdp_cmd_e;

   typedef struct packed {
      mdp_bank_e  state;
      logic       apArm;
      logic [3:0] apCnt;
      logic [3:0] rpCnt;
      logic [3:0] wrCnt;
      logic [3:0] wtrCnt;
   } mdp_bank_s;

   typedef struct packed {
      mdp_pwr_e    pwr;
      logic        ckePrev;
      logic [2:0]  wrBurst;
      logic [2:0]  rdBurst;
      logic        wrTrunc;
      logic [1:0]  wrBank;
      logic [12:0] refRow;
      logic [11:0] srTimer;
      logic [7:0]  stayCnt;
      logic        arrayValid;
      logic        modeValid;
      logic        storeEn;
      logic        refreshPulse;
      logic        timingErr;
   } mdp_core_s;

   // mode register set shares the all-low code; reported as nop here
   function automatic mdp_cmd_e mdp_decode(input logic csN, input logic rasN,
                                           input logic casN, input logic weN);
      if (csN)
         return CMD_DESEL;
      case ({rasN, casN, weN})
         3'h7:    return CMD_NOP;
         3'h3:    return CMD_ACT;
         3'h5:    return CMD_RD;
         3'h4:    return CMD_WR;
         3'h6:    return CMD_BST;
         3'h2:    return CMD_PRE;
         3'h1:    return CMD_AREF;
         default: return CMD_NOP;
      endcase
   endfunction : mdp_decode
endpackage : mdp_pkg

//--- core/mdp_bank.sv
// state and cycle counters of one dram bank
`timescale 1ns/100ps
`include "mdp_params.svh"
module mdp_bank import mdp_pkg::*; #(
   parameter int BURST_PAIRS = `MDP_BURST_PAIRS,
   parameter int T_RP        = `MDP_T_RP,
   parameter int T_WR        = `MDP_T_WR,
   parameter int T_WTR       = `MDP_T_WTR
) (
   // clock and reset
   input  wire logic      clk,
   input  wire logic      sys_rst,
   // decoded commands for this bank
   input  wire logic      actCmd,
   input  wire logic      preCmd,
   input  wire logic      accCmd,
   input  wire logic      accWrite,
   input  wire logic      autoPre,
   // status
   output mdp_bank_e      bankState,
   output logic           wrRecBusy,
   output logic           wtrBusy
);
   mdp_bank_s s_r, s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (s_r.rpCnt != 4'h0) s_nxt.rpCnt = s_r.rpCnt - 4'h1;
      if (s_r.apCnt != 4'h0) s_nxt.apCnt = s_r.apCnt - 4'h1;
      if (s_r.wrCnt != 4'h0) s_nxt.wrCnt = s_r.wrCnt - 4'h1;
      if (s_r.wtrCnt != 4'h0) s_nxt.wtrCnt = s_r.wtrCnt - 4'h1;
      case (s_r.state)
         BK_IDLE: begin
            // (R8) precharge here is ignored
            if (actCmd)
               s_nxt.state = BK_ACTIVE;
         end
         BK_ACTIVE: begin
            if (preCmd) begin
               // (R5) close row, start tRP
               s_nxt.state = BK_PRECHG;
               s_nxt.rpCnt = 4'(T_RP);
               s_nxt.apArm = 1'b0;
            end else if (accCmd) begin
               // (R24) per-bank write counters
               if (accWrite) begin
                  s_nxt.wrCnt  = 4'(BURST_PAIRS + T_WR);
                  s_nxt.wtrCnt = 4'(BURST_PAIRS + T_WTR);
               end
               // (R9) arm auto precharge
               if (autoPre) begin
                  s_nxt.apArm = 1'b1;
                  s_nxt.apCnt = accWrite ? 4'(BURST_PAIRS + T_WR) : 4'(BURST_PAIRS);
               end
            end else if (s_r.apArm && s_r.apCnt <= 4'h1) begin
               // (R9) precharge at the earliest legal point
               s_nxt.state = BK_PRECHG;
               s_nxt.rpCnt = 4'(T_RP);
               s_nxt.apArm = 1'b0;
            end
         end
         BK_PRECHG: begin
            // (R5) activation waits for the count to expire
            if (s_r.rpCnt <= 4'h1)
               s_nxt.state = BK_IDLE;
         end
         default: s_nxt.state = BK_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         s_r <= '{state: BK_IDLE, default: '0};
      else
         s_r <= s_nxt;
   end

   assign bankState = s_r.state;
   assign wrRecBusy = s_r.wrCnt != 4'h0;
   assign wtrBusy   = s_r.wtrCnt != 4'h0;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   act_block_a: assert property (@(posedge clk) disable iff (sys_rst) // (R5)
      s_r.state == BK_PRECHG && s_r.rpCnt > 4'h1 && actCmd |=> s_r.state == BK_PRECHG)
      else $error("activation accepted during precharge");
   nop_pre_a: assert property (@(posedge clk) disable iff (sys_rst) // (R8)
      s_r.state == BK_IDLE && preCmd && !actCmd |=> s_r.state == BK_IDLE)
      else $error("precharge of idle bank changed state");
   auto_pre_a: assert property (@(posedge clk) disable iff (sys_rst) // (R9)
      s_r.state == BK_ACTIVE && accCmd && autoPre && !accWrite && !preCmd
      |-> ##[1:16] s_r.state == BK_PRECHG)
      else $error("auto precharge did not start");
   auto_pre_c: cover property (@(posedge clk) disable iff (sys_rst)
      s_r.apArm ##1 s_r.state == BK_PRECHG);
endmodule : mdp_bank

//--- core/mdp_core.sv
// command decode, write truncation, refresh and power states of the dram core
`timescale 1ns/100ps
`include "mdp_params.svh"
module mdp_core import mdp_pkg::*; #(
   parameter int BURST_PAIRS = `MDP_BURST_PAIRS,
   parameter int T_RP        = `MDP_T_RP,
   parameter int T_WR        = `MDP_T_WR,
   parameter int T_WTR       = `MDP_T_WTR,
   parameter int T_RFC       = `MDP_T_RFC,
   parameter int T_CKE       = `MDP_T_CKE,
   parameter int REFI_CYC    = `MDP_REFI_CYC
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // command pins, sampled on clk
   input  wire logic        cke,
   input  wire logic        csN,
   input  wire logic        rasN,
   input  wire logic        casN,
   input  wire logic        weN,
   input  wire logic [1:0]  ba,
   input  wire logic [12:0] addr,
   // write data pairs
   input  wire logic        wrDataValid,
   input  wire logic        dataMask,
   // status
   output mdp_bank_e [3:0]  bankState,
   output mdp_pwr_e         pwrMode,
   output logic [12:0]      refreshRow,
   output logic             refreshPulse,
   output logic             storeEn,
   output logic             arrayValid,
   output logic             modeValid,
   output logic             timingErr
);
   mdp_core_s s_r, s_nxt;
   mdp_cmd_e  cmd;
   logic      cmdOn;
   logic      mrsCmd;
   logic      anyActive;
   logic      bursting;
   logic [3:0] actCmd, preCmd, accCmd, wrRecBusy, wtrBusy;

   // pins are launched on the same clock edge by the controller, so no synchroniser
   assign cmd      = mdp_decode(csN, rasN, casN, weN);
   assign mrsCmd   = !csN && !rasN && !casN && !weN;
   assign cmdOn    = cke && s_r.ckePrev && s_r.pwr == PW_NORMAL;
   assign bursting = s_r.wrBurst != 3'h0 || s_r.rdBurst != 3'h0;

   // ----------------------------------------
   // bank fan-out
   // ----------------------------------------
   always_comb begin
      anyActive = 1'b0;
      for (int i = 0; i < 4; i++) begin
         actCmd[i] = cmdOn && cmd == CMD_ACT && ba == 2'(i);
         // (R6) bit ten selects all banks
         preCmd[i] = cmdOn && cmd == CMD_PRE && (addr[`MDP_A10] || ba == 2'(i));
         accCmd[i] = cmdOn && (cmd == CMD_RD || cmd == CMD_WR) && ba == 2'(i);
         anyActive = anyActive || bankState[i] == BK_ACTIVE;
      end
   end

   for (genvar g = 0; g < 4; g++) begin : gBank
      mdp_bank #(
         .BURST_PAIRS (BURST_PAIRS),
         .T_RP        (T_RP),
         .T_WR        (T_WR),
         .T_WTR       (T_WTR)
      ) uBank (
         .clk       (clk),
         .sys_rst   (sys_rst),
         .actCmd    (actCmd[g]),
         .preCmd    (preCmd[g]),
         .accCmd    (accCmd[g]),
         .accWrite  (cmd == CMD_WR),
         .autoPre   (addr[`MDP_A10]),
         .bankState (bankState[g]),
         .wrRecBusy (wrRecBusy[g]),
         .wtrBusy   (wtrBusy[g])
      );
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      s_nxt              = s_r;
      s_nxt.ckePrev      = cke;
      s_nxt.refreshPulse = 1'b0;
      // (R2) pairs after truncation are dropped even if unmasked
      s_nxt.storeEn = wrDataValid && !dataMask && s_r.wrBurst != 3'h0 && !s_r.wrTrunc;
      if (s_r.wrBurst != 3'h0) s_nxt.wrBurst = s_r.wrBurst - 3'h1;
      if (s_r.rdBurst != 3'h0) s_nxt.rdBurst = s_r.rdBurst - 3'h1;
      if (s_r.stayCnt != 8'hFF) s_nxt.stayCnt = s_r.stayCnt + 8'h01;
      case (s_r.pwr)
         PW_NORMAL: begin
            if (cmdOn) begin
               if (mrsCmd) begin
                  s_nxt.modeValid  = 1'b1;
                  s_nxt.arrayValid = 1'b1;
               end else begin
                  case (cmd)
                     CMD_WR: begin
                        s_nxt.wrBurst = 3'(BURST_PAIRS);
                        s_nxt.wrTrunc = 1'b0;
                        s_nxt.wrBank  = ba;
                     end
                     CMD_RD: begin
                        s_nxt.rdBurst = 3'(BURST_PAIRS);
                        // (R2) read inside the turnaround window truncates
                        if (s_r.wrBurst != 3'h0 || (|wtrBusy))
                           s_nxt.wrTrunc = 1'b1;
                     end
                     CMD_PRE: begin
                        // (R4) precharge of the written bank truncates
                        if ((addr[`MDP_A10] || ba == s_r.wrBank) &&
                            (s_r.wrBurst != 3'h0 || wrRecBusy[s_r.wrBank]))
                           s_nxt.wrTrunc = 1'b1;
                     end
                     CMD_AREF: begin
                        // (R12) internal row counter
                        s_nxt.refRow       = s_r.refRow + 13'h0001;
                        s_nxt.refreshPulse = 1'b1;
                     end
                     default: ;
                  endcase
               end
            end else if (s_r.ckePrev && !cke) begin
               s_nxt.stayCnt = 8'h00;
               if (!csN && cmd == CMD_AREF) begin
                  // (R13) self refresh entry
                  s_nxt.pwr     = PW_SELF_REF;
                  s_nxt.srTimer = 12'h000;
               end else if (!csN && cmd == CMD_BST) begin
                  // (R19) burst terminate entry
                  // (R20) contents and mode settings lost
                  s_nxt.pwr        = PW_DEEPEST;
                  s_nxt.arrayValid = 1'b0;
                  s_nxt.modeValid  = 1'b0;
               end else if (!bursting) begin
                  // (R16) kind follows open rows
                  s_nxt.pwr = anyActive ? PW_ACT_PD : PW_PRE_PD;
               end
            end
         end
         PW_SELF_REF: begin
            // (R14) internal refresh timer
            if (s_r.srTimer >= 12'(REFI_CYC - 1)) begin
               s_nxt.srTimer      = 12'h000;
               s_nxt.refRow       = s_r.refRow + 13'h0001;
               s_nxt.refreshPulse = 1'b1;
            end else begin
               s_nxt.srTimer = s_r.srTimer + 12'h001;
            end
            if (cke) begin
               s_nxt.pwr = PW_NORMAL;
               // (R14) early exit flagged
               if (s_r.stayCnt < 8'(T_RFC))
                  s_nxt.timingErr = 1'b1;
            end
         end
         PW_PRE_PD, PW_ACT_PD: begin
            if (cke) begin
               s_nxt.pwr = PW_NORMAL;
               // (R17) minimum stay and nop on exit
               if (s_r.stayCnt < 8'(T_CKE) || !(cmd == CMD_NOP || cmd == CMD_DESEL))
                  s_nxt.timingErr = 1'b1;
            end
         end
         PW_DEEPEST: begin
            // reinitialisation is the controller's job after this
            if (cke)
               s_nxt.pwr = PW_NORMAL;
         end
         default: s_nxt.pwr = PW_NORMAL;
      endcase
      // (R2) pair arriving with the truncating command is dropped too
      s_nxt.storeEn = s_nxt.storeEn && !s_nxt.wrTrunc;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         s_r <= '{pwr: PW_NORMAL, arrayValid: `MDP_ARRAY_RST, modeValid: `MDP_MODE_RST,
                  default: '0};
      else
         s_r <= s_nxt;
   end

   assign pwrMode      = s_r.pwr;
   assign refreshRow   = s_r.refRow;
   assign refreshPulse = s_r.refreshPulse;
   assign storeEn      = s_r.storeEn;
   assign arrayValid   = s_r.arrayValid;
   assign modeValid    = s_r.modeValid;
   assign timingErr    = s_r.timingErr;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   store_trunc_a: assert property (@(posedge clk) disable iff (sys_rst) // (R2)
      s_r.wrTrunc && wrDataValid |=> !storeEn)
      else $error("truncated write pair was stored");
   pre_one_a: assert property (@(posedge clk) disable iff (sys_rst) // (R6)
      cmdOn && cmd == CMD_PRE && !addr[`MDP_A10] && bankState[ba] == BK_ACTIVE
      |=> bankState[$past(ba)] == BK_PRECHG)
      else $error("single bank precharge missed its bank");
   pre_all_a: assert property (@(posedge clk) disable iff (sys_rst) // (R5)
      cmdOn && cmd == CMD_PRE && addr[`MDP_A10] |=> !anyActive)
      else $error("precharge all left a row open");
   ref_count_a: assert property (@(posedge clk) disable iff (sys_rst) // (R12)
      cmdOn && cmd == CMD_AREF && !mrsCmd |=> refreshRow == $past(refreshRow) + 13'h0001)
      else $error("refresh row did not advance");
   sref_entry_a: assert property (@(posedge clk) disable iff (sys_rst) // (R13)
      s_r.pwr == PW_NORMAL && s_r.ckePrev && !cke && !csN && cmd == CMD_AREF
      |=> pwrMode == PW_SELF_REF)
      else $error("self refresh not entered");
   deep_loss_a: assert property (@(posedge clk) disable iff (sys_rst) // (R20)
      $rose(pwrMode == PW_DEEPEST) |-> !arrayValid && !modeValid)
      else $error("deepest sleep kept contents");
   pd_kind_a: assert property (@(posedge clk) disable iff (sys_rst) // (R16)
      s_r.pwr == PW_NORMAL && s_r.ckePrev && !cke && !bursting &&
      (csN || (cmd != CMD_AREF && cmd != CMD_BST))
      |=> pwrMode == ($past(anyActive) ? PW_ACT_PD : PW_PRE_PD))
      else $error("wrong power-down kind");
   sref_c: cover property (@(posedge clk) disable iff (sys_rst)
      pwrMode == PW_SELF_REF ##1 refreshPulse);
   deep_c: cover property (@(posedge clk) disable iff (sys_rst)
      pwrMode == PW_DEEPEST ##1 pwrMode == PW_NORMAL);
   trunc_c: cover property (@(posedge clk) disable iff (sys_rst)
      s_r.wrTrunc && wrDataValid && s_r.wrBurst != 3'h0);
endmodule : mdp_core

//--- test/mdp_host.sv
// controller model that drives the dram command, clock-enable and data-mask pins
`timescale 1ns/100ps
module mdp_host (
   // clock
   input  wire logic        clk,
   // command pins
   output logic             cke,
   output logic             csN,
   output logic             rasN,
   output logic             casN,
   output logic             weN,
   output logic [1:0]       ba,
   output logic [12:0]      addr,
   // write data pairs
   output logic             wrDataValid,
   output logic             dataMask
);
   initial begin
      cke         = 1'b1;
      csN         = 1'b1;
      {rasN, casN, weN} = 3'h7;
      ba          = 2'h0;
      addr        = 13'h0000;
      wrDataValid = 1'b0;
      dataMask    = 1'b1;
   end

   task automatic send(input logic [2:0] op, input logic [1:0] bank, input logic [12:0] adr,
                       input logic en, input logic dv, input logic dm);
      cke         = en;
      csN         = 1'b0;
      {rasN, casN, weN} = op;
      ba          = bank;
      addr        = adr;
      wrDataValid = dv;
      dataMask    = dm;
      @(negedge clk);
   endtask : send

   // nops alternate with deselects to fill gaps
   // don't-care pins toggle so a stale value is never mistaken for a held one
   task automatic idle(input int n);
      repeat (n) begin
         csN         = ~csN;
         {rasN, casN, weN} = 3'h7;
         ba          = ~ba;
         addr        = ~addr;
         wrDataValid = 1'b0;
         dataMask    = ~dataMask;
         @(negedge clk);
      end
   endtask : idle
endmodule : mdp_host

//--- test/mdp_core_tb.sv
// self-checking bench for the dram command core
`timescale 1ns/100ps
module mdp_core_tb;
   import mdp_pkg::*;
   // ----------------------------------------
   // constants and signals
   // ----------------------------------------
   localparam int          T_RP   = 5;
   localparam logic [2:0]  OP_NOP = 3'h7;
   localparam logic [2:0]  OP_ACT = 3'h3;
   localparam logic [2:0]  OP_RD  = 3'h5;
   localparam logic [2:0]  OP_WR  = 3'h4;
   localparam logic [2:0]  OP_BST = 3'h6;
   localparam logic [2:0]  OP_PRE = 3'h2;
   localparam logic [2:0]  OP_REF = 3'h1;
   localparam logic [2:0]  OP_MRS = 3'h0;
   localparam logic [12:0] A10    = 13'h0400;
   logic                   clk = 1'b0;
   logic                   sys_rst = 1'b1;
   logic                   cke, csN, rasN, casN, weN, wrDataValid, dataMask;
   logic [1:0]             ba;
   logic [12:0]            addr;
   mdp_bank_e [3:0]        bankState;
   mdp_pwr_e               pwrMode;
   logic [12:0]            refreshRow;
   logic                   refreshPulse, storeEn, arrayValid, modeValid, timingErr;
   int                     miscompares = 0;
   int                     checked = 0;
   int                     storeCnt = 0;
   int                     refCnt = 0;
   int                     n;
   int                     s0;
   logic [12:0]            col = 13'h0000;

   always #2 clk = ~clk;
   // short refresh interval keeps self refresh visible in a short run
   mdp_core #(.REFI_CYC(20)) i_mdp_core (.clk(clk), .sys_rst(sys_rst), .cke(cke), .csN(csN),
      .rasN(rasN), .casN(casN), .weN(weN), .ba(ba), .addr(addr), .wrDataValid(wrDataValid),
      .dataMask(dataMask), .bankState(bankState), .pwrMode(pwrMode), .refreshRow(refreshRow),
      .refreshPulse(refreshPulse), .storeEn(storeEn), .arrayValid(arrayValid),
      .modeValid(modeValid), .timingErr(timingErr));
   mdp_host i_mdp_host (.clk(clk), .cke(cke), .csN(csN), .rasN(rasN), .casN(casN), .weN(weN),
      .ba(ba), .addr(addr), .wrDataValid(wrDataValid), .dataMask(dataMask));
   always @(posedge clk) storeCnt <= storeCnt + int'(storeEn);
   always @(posedge clk) refCnt <= refCnt + int'(refreshPulse);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic end_of_test();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_of_test

   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask : check

   task automatic hang(input string what);
      miscompares++;
      $display("CHECK FAILED at %0t: no progress on %s", $time, what);
      end_of_test();
   endtask : hang

   task automatic cmd(input logic [2:0] op, input logic [1:0] bank, input logic [12:0] adr,
                      input logic en = 1'b1, input logic dv = 1'b0, input logic dm = 1'b1);
      // column bits roll so the address pins never sit still
      col = (col + 13'h0093) & ~A10;
      i_mdp_host.send(op, bank, adr | col, en, dv, dm);
   endtask : cmd

   task automatic wait_bank(input int b, input mdp_bank_e st, output int k);
      k = 0;
      while (bankState[b] !== st) begin
         if (k == 40)
            hang("bank state");
         @(negedge clk);
         k++;
      end
   endtask : wait_bank

   task automatic wait_pwr(input mdp_pwr_e m);
      for (int k = 0; pwrMode !== m; k++) begin
         if (k == 10)
            hang("power mode");
         @(negedge clk);
      end
   endtask : wait_pwr

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      check(16'(bankState), 16'h0000, "banks idle");
      check(16'(pwrMode), 16'(PW_NORMAL), "mode");
      check(16'(refreshRow), 16'h0000, "row");
      check(16'({arrayValid, modeValid, timingErr}), 16'h0006, "flags");
      $display("test reset done");
   endtask : t_reset

   task automatic t_autopre();
      cmd(OP_ACT, 2'h1, 13'h0000);
      cmd(OP_RD, 2'h1, A10);
      i_mdp_host.idle(1);
      wait_bank(1, BK_PRECHG, n);
      wait_bank(1, BK_IDLE, n);
      check(16'(n), 16'(T_RP), "auto precharge length");
      cmd(OP_ACT, 2'h1, 13'h0000);
      cmd(OP_RD, 2'h1, 13'h0000);
      i_mdp_host.idle(10);
      check(16'(bankState[1]), 16'(BK_ACTIVE), "no persistence");
      $display("test auto precharge done");
   endtask : t_autopre

   task automatic t_precharge();
      cmd(OP_ACT, 2'h0, 13'h0000);
      cmd(OP_ACT, 2'h2, 13'h0000);
      cmd(OP_PRE, 2'h1, A10);
      i_mdp_host.idle(1);
      check(16'(bankState), 16'({BK_IDLE, BK_PRECHG, BK_PRECHG, BK_PRECHG}), "all");
      wait_bank(2, BK_IDLE, n);
      cmd(OP_ACT, 2'h3, 13'h0000);
      cmd(OP_PRE, 2'h3, 13'h0000);
      cmd(OP_PRE, 2'h3, 13'h0000);
      cmd(OP_PRE, 2'h2, 13'h0000);
      i_mdp_host.idle(1);
      check(16'(bankState[2]), 16'(BK_IDLE), "idle stays idle");
      wait_bank(3, BK_IDLE, n);
      check(16'(n), 16'(T_RP - 3), "second precharge ignored");
      cmd(OP_ACT, 2'h0, 13'h0000);
      cmd(OP_ACT, 2'h3, 13'h0000);
      cmd(OP_PRE, 2'h3, 13'h0000);
      i_mdp_host.idle(1);
      check(16'({bankState[3], bankState[0]}), 16'({BK_PRECHG, BK_ACTIVE}), "one bank");
      wait_bank(3, BK_IDLE, n);
      $display("test precharge done");
   endtask : t_precharge

   task automatic t_write();
      s0 = storeCnt;
      cmd(OP_WR, 2'h0, 13'h0000);
      cmd(OP_NOP, 2'h0, 13'h0000, 1'b1, 1'b1, 1'b0);
      cmd(OP_NOP, 2'h0, 13'h0000, 1'b1, 1'b1, 1'b1);
      i_mdp_host.idle(3);
      check(16'(storeCnt - s0), 16'h0001, "masked pair");
      s0 = storeCnt;
      cmd(OP_WR, 2'h0, 13'h0000);
      cmd(OP_RD, 2'h0, 13'h0000, 1'b1, 1'b1, 1'b0);
      cmd(OP_NOP, 2'h0, 13'h0000, 1'b1, 1'b1, 1'b0);
      i_mdp_host.idle(3);
      check(16'(storeCnt - s0), 16'h0000, "read truncation");
      s0 = storeCnt;
      cmd(OP_WR, 2'h0, 13'h0000);
      cmd(OP_PRE, 2'h0, 13'h0000, 1'b1, 1'b1, 1'b0);
      cmd(OP_NOP, 2'h0, 13'h0000, 1'b1, 1'b1, 1'b0);
      i_mdp_host.idle(1);
      wait_bank(0, BK_IDLE, n);
      check(16'(n), 16'(T_RP - 2), "precharge after truncation");
      check(16'(storeCnt - s0), 16'h0000, "precharge truncation");
      $display("test write done");
   endtask : t_write

   task automatic t_power();
      logic [12:0] r0;
      r0 = refreshRow;
      s0 = refCnt;
      cmd(OP_REF, 2'h0, 13'h0000);
      cmd(OP_REF, 2'h0, 13'h0000);
      i_mdp_host.idle(2);
      check(16'(refreshRow), 16'(r0 + 13'h0002), "row counter");
      check(16'(refCnt - s0), 16'h0002, "refresh pulses");
      cmd(OP_ACT, 2'h2, 13'h0000);
      i_mdp_host.idle(1);
      cmd(OP_NOP, 2'h0, 13'h0000, 1'b0);
      wait_pwr(PW_ACT_PD);
      check(16'(pwrMode), 16'(PW_ACT_PD), "active power-down");
      i_mdp_host.idle(4);
      cmd(OP_NOP, 2'h0, 13'h0000, 1'b1);
      wait_pwr(PW_NORMAL);
      cmd(OP_PRE, 2'h2, 13'h0000);
      i_mdp_host.idle(1);
      wait_bank(2, BK_IDLE, n);
      cmd(OP_NOP, 2'h0, 13'h0000, 1'b0);
      wait_pwr(PW_PRE_PD);
      check(16'(pwrMode), 16'(PW_PRE_PD), "precharge power-down");
      i_mdp_host.idle(4);
      cmd(OP_NOP, 2'h0, 13'h0000, 1'b1);
      wait_pwr(PW_NORMAL);
      check(16'(timingErr), 16'h0000, "clean exit");
      s0 = refCnt;
      cmd(OP_REF, 2'h0, 13'h0000, 1'b0);
      wait_pwr(PW_SELF_REF);
      i_mdp_host.idle(30);
      check(16'(refCnt - s0 != 0), 16'h0001, "own refresh timer");
      cmd(OP_NOP, 2'h0, 13'h0000, 1'b1);
      wait_pwr(PW_NORMAL);
      i_mdp_host.idle(2);
      check(16'(timingErr), 16'h0000, "self refresh exit");
      $display("test refresh and power-down done");
   endtask : t_power

   task automatic t_deepest();
      cmd(OP_BST, 2'h0, 13'h0000, 1'b0);
      wait_pwr(PW_DEEPEST);
      i_mdp_host.idle(1);
      check(16'({arrayValid, modeValid}), 16'h0000, "contents lost");
      i_mdp_host.idle(4);
      cmd(OP_NOP, 2'h0, 13'h0000, 1'b1);
      wait_pwr(PW_NORMAL);
      i_mdp_host.idle(2);
      cmd(OP_MRS, 2'h0, 13'h0000);
      i_mdp_host.idle(2);
      check(16'({arrayValid, modeValid}), 16'h0003, "reinitialised");
      // too short a stay in self refresh is flagged
      cmd(OP_REF, 2'h0, 13'h0000, 1'b0);
      wait_pwr(PW_SELF_REF);
      cmd(OP_NOP, 2'h0, 13'h0000, 1'b1);
      wait_pwr(PW_NORMAL);
      i_mdp_host.idle(2);
      check(16'(timingErr), 16'h0001, "early exit");
      sys_rst = 1'b1;
      i_mdp_host.idle(3);
      sys_rst = 1'b0;
      i_mdp_host.idle(2);
      check(16'({timingErr, pwrMode}), 16'(PW_NORMAL), "second reset");
      $display("test deepest sleep done");
   endtask : t_deepest

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (20) @(negedge clk);
      sys_rst = 1'b0;
      i_mdp_host.idle(2);
      t_reset();
      t_autopre();
      t_precharge();
      t_write();
      t_power();
      t_deepest();
      end_of_test();
   end

   initial begin
      #100000;
      hang("whole run");
   end
endmodule : mdp_core_tb
